// File: design/spf_baud.sv
// Master baud divider: one tick per serial clock half period
// Assumes mclk is the bus clock and nrst its asynchronous reset
`timescale 1ns/1ps
`include "spf_map.svh"
module spf_baud (
  input wire logic mclk,
  input wire logic nrst,
  spf_baud_if.gen bif
);

  logic [6:0] cnt_q;
  logic tick_q;
  logic [6:0] half;

  function automatic logic [7:0] div_of(input logic [1:0] code);
    unique case (code)
      2'b00: div_of = `SPF_BD_00;
      2'b01: div_of = `SPF_BD_01;
      2'b10: div_of = `SPF_BD_10;
      2'b11: div_of = `SPF_BD_11;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // [R17] Divisor selection
  assign half = 7'(div_of(bif.rate_sel) >> 1) - 7'h01;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    // [R18] Idle when slave
    end else if (!bif.run) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= half) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      tick_q <= 1'b0;
    end
  end

  assign bif.tick = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_div8_run;
    (bif.run && bif.rate_sel == 2'b01 && tick_q)
      ##1 (bif.run && bif.rate_sel == 2'b01) [*4];
  endsequence

  a_div8_period: assert property ( // [R17]
    @(posedge mclk) disable iff (!nrst)
    s_div8_run |-> tick_q && !$past(tick_q, 1) && !$past(tick_q, 2)
      && !$past(tick_q, 3))
    else $error("divide by 8 tick spacing wrong");

  a_slave_no_tick: assert property ( // [R18]
    @(posedge mclk) disable iff (!nrst)
    !bif.run |=> !tick_q)
    else $error("baud tick while not master");

endmodule

// File: design/spf_baud_if.sv
// Link between the flag block and its baud divider
// Assumes both ends run on the same clock
`timescale 1ns/1ps
interface spf_baud_if;
  logic run;
  logic [1:0] rate_sel;
  logic tick;
  modport ctl (output run, output rate_sel, input tick);
  modport gen (input run, input rate_sel, output tick);
endinterface

// File: design/spf_map.svh
// Offsets, field positions, reset values and divisors of the SPI flag block
// Assumes inclusion by bare name from the block's design files
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

// Register indexes; byte address is four times the index
`define SPF_IDX_CTRL 8'h10
`define SPF_IDX_STAT 8'h11
`define SPF_IDX_DATA 8'h12

// Control register fields
`define SPF_C_RXIE 7
`define SPF_C_MSTR 5
`define SPF_C_CPOL 4
`define SPF_C_CPHA 3
`define SPF_C_WOM 2
`define SPF_C_SPE 1
`define SPF_C_TXIE 0
`define SPF_CTRL_RST 8'h28
`define SPF_CTRL_MASK 8'hBF

// Status and control register fields
`define SPF_S_RXF 7
`define SPF_S_ERROR_IRQ_ENABLE 6
`define SPF_S_OVR 5
`define SPF_S_MODE_FAULT_FLAG 4
`define SPF_S_TXE 3
`define SPF_S_FAULT_DETECT_ENABLE 2
`define SPF_S_RATE_HI 1
`define SPF_S_RATE_LO 0

// Baud rate divisors per rate code
`define SPF_BD_00 8'h02
`define SPF_BD_01 8'h08
`define SPF_BD_10 8'h20
`define SPF_BD_11 8'h80

`endif

// File: design/spf_pkg.sv
// Types shared by the SPI flag block
// Assumes the map header is compiled alongside
package spf_pkg;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_STAT,
    SEL_DATA
  } spf_sel_t;

  typedef enum logic {
    AP_IDLE,
    AP_ANS
  } spf_apb_st_t;

endpackage

// File: design/spf_top.sv
// SPI status flags, control registers, data port and baud selection
// Assumes an APB master on mclk and a shifter giving one-cycle pulses
//
// What this block does
// [R1] Set receive full whenever a received byte lands in receive register.
// [R2] Request interrupt while receive full and its enable are both set.
// [R3] Clear receive full by status read with flag set, then data read.
// [R4] Error enable gates overrun and mode fault interrupts; reset clears it.
// [R5] Set overrun when a new byte arrives before old byte was read.
// [R6] On overrun keep the old received byte, drop the new one.
// [R7] Clear overrun by status read with flag set, then data read.
// [R8] Slave with fault detect: select rising mid-transfer sets mode fault.
// [R9] Master with fault detect: select falling at any time sets mode fault.
// [R10] Clear mode fault by status read with flag set, then control write.
// [R11] Set transmit empty on hand-over to shifter; interrupt with its enable.
// [R12] Writing transmit data clears transmit empty; reset sets it.
// [R13] Software writes data only while transmit empty reads high.
// [R14] Mode fault sets only with fault detect on; disabling keeps it.
// [R15] Select pin taken from port when fault detect on or slave.
// [R16] Slave with fault detect off only suppresses mode fault setting.
// [R17] Master serial clock is bus clock over 2, 8, 32 or 128.
// [R18] Rate code ignored as slave; reset clears it.
// [R19] Data writes go to transmit, reads from receive; neither reset.
// [R20] Software avoids read-modify-write on the data register.
// [R21] Slave only when master bit clear and select low; else no drive.
// [R22] Data write during protected debug break has no effect at all.
// [R23] One interrupt output is the OR of all enabled flag terms.
// [R24] Second clear step works only after a status read with flag set.
`timescale 1ns/1ps
`include "spf_map.svh"
module spf_top #(
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_done,
  input wire logic [7:0] rx_byte,
  input wire logic tx_load,
  output logic [7:0] tx_data,
  output logic tx_pending,
  input wire logic slave_select_n,
  input wire logic xfer_active,
  input wire logic break_active,
  input wire logic break_clear_enable,
  output logic irq,
  output logic ss_owned,
  output logic miso_oe,
  output logic baud_tick,
  output logic spi_enable,
  output logic master_mode,
  output logic clk_polarity,
  output logic clk_phase,
  output logic wired_or
);

  spf_baud_if bif ();

  spf_pkg::spf_apb_st_t st_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [7:0] ctrl_q;
  logic error_irq_enable_q;
  logic fault_detect_enable_q;
  logic [1:0] rate_q;
  logic rx_full_q;
  logic ovr_q;
  logic mode_fault_flag_q;
  logic tx_empty_q;
  logic [7:0] rx_hold_q;
  logic [7:0] tx_hold_q;
  logic arm_rx_q;
  logic arm_ovr_q;
  logic arm_mode_fault_flag_q;
  logic ssn_prev_q;
  logic irq_q;
  logic ss_owned_q;
  logic miso_oe_q;
  logic baud_tick_q;
  logic fire;
  logic brk_block;
  logic rd_stat;
  logic rd_data;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic rx_clr;
  logic ovr_clr;
  logic mode_fault_flag_clr;
  logic rx_accept;
  logic mode_fault_flag_set;
  logic [7:0] stat_val;

  function automatic spf_pkg::spf_sel_t decode(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'b00)
      decode = spf_pkg::SEL_NONE;
    else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`SPF_IDX_CTRL))
      decode = spf_pkg::SEL_CTRL;
    else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`SPF_IDX_STAT))
      decode = spf_pkg::SEL_STAT;
    else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`SPF_IDX_DATA))
      decode = spf_pkg::SEL_DATA;
    else
      decode = spf_pkg::SEL_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, access completes on the second edge
  assign fire = (st_q == spf_pkg::AP_ANS) && psel && penable;
  assign rd_stat = fire && !pwrite && decode(paddr) == spf_pkg::SEL_STAT;
  assign rd_data = fire && !pwrite && decode(paddr) == spf_pkg::SEL_DATA;
  assign wr_ctrl = fire && pwrite && decode(paddr) == spf_pkg::SEL_CTRL;
  assign wr_stat = fire && pwrite && decode(paddr) == spf_pkg::SEL_STAT;
  assign wr_data = fire && pwrite && decode(paddr) == spf_pkg::SEL_DATA;

  assign stat_val = {rx_full_q, error_irq_enable_q, ovr_q, mode_fault_flag_q, tx_empty_q,
                     fault_detect_enable_q, rate_q};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= spf_pkg::AP_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      unique case (st_q)
        spf_pkg::AP_IDLE: begin
          if (psel && penable) begin
            st_q <= spf_pkg::AP_ANS;
            pready_q <= 1'b1;
            pslverr_q <= decode(paddr) == spf_pkg::SEL_NONE;
            unique case (decode(paddr))
              spf_pkg::SEL_CTRL: prdata_q <= {24'h00_0000, ctrl_q};
              spf_pkg::SEL_STAT: prdata_q <= {24'h00_0000, stat_val};
              // [R19] Reads from receive side
              spf_pkg::SEL_DATA: prdata_q <= {24'h00_0000, rx_hold_q};
              spf_pkg::SEL_NONE: prdata_q <= 32'h0000_0000;
            endcase
          end
        end
        spf_pkg::AP_ANS: begin
          st_q <= spf_pkg::AP_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `SPF_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[7:0] & `SPF_CTRL_MASK;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      error_irq_enable_q <= 1'b0;
      fault_detect_enable_q <= 1'b0;
      rate_q <= 2'b00;
    end else if (wr_stat) begin
      error_irq_enable_q <= pwdata[`SPF_S_ERROR_IRQ_ENABLE];
      fault_detect_enable_q <= pwdata[`SPF_S_FAULT_DETECT_ENABLE];
      rate_q <= {pwdata[`SPF_S_RATE_HI], pwdata[`SPF_S_RATE_LO]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-step clear arming and clear strobes
  assign brk_block = break_active && !break_clear_enable;

  // [R24] Arm on status read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arm_rx_q <= 1'b0;
      arm_ovr_q <= 1'b0;
      arm_mode_fault_flag_q <= 1'b0;
    end else begin
      if (rd_stat && rx_full_q)
        arm_rx_q <= 1'b1;
      else if (rx_clr)
        arm_rx_q <= 1'b0;
      if (rd_stat && ovr_q)
        arm_ovr_q <= 1'b1;
      else if (ovr_clr)
        arm_ovr_q <= 1'b0;
      if (rd_stat && mode_fault_flag_q)
        arm_mode_fault_flag_q <= 1'b1;
      else if (mode_fault_flag_clr)
        arm_mode_fault_flag_q <= 1'b0;
    end
  end

  // [R3] Receive full clear step
  assign rx_clr = rd_data && arm_rx_q && !brk_block;
  // [R7] Overrun clear step
  assign ovr_clr = rd_data && arm_ovr_q && !brk_block;
  // [R10] Mode fault clear step
  assign mode_fault_flag_clr = wr_ctrl && arm_mode_fault_flag_q && !brk_block;

  ////////////////////////////////////////////////////////////////////////////
  // Receive side
  // [R6] Drop byte on overrun
  assign rx_accept = rx_done && (!rx_full_q || rx_clr);

  // [R19] Receive holding register
  always_ff @(posedge mclk) begin
    if (rx_accept)
      rx_hold_q <= rx_byte;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_full_q <= 1'b0;
    // [R1] Set wins over clear
    end else if (rx_done) begin
      rx_full_q <= 1'b1;
    end else if (rx_clr) begin
      rx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ovr_q <= 1'b0;
    // [R5] Overrun set
    end else if (rx_done && !rx_accept) begin
      ovr_q <= 1'b1;
    end else if (ovr_clr) begin
      ovr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode fault detection
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      ssn_prev_q <= 1'b1;
    else
      ssn_prev_q <= slave_select_n;
  end

  // [R8] Slave deselect mid-transfer
  // [R9] Master select falling
  // [R14] Gated by fault detect
  // [R16] Only the flag is gated
  assign mode_fault_flag_set = ctrl_q[`SPF_C_SPE] && fault_detect_enable_q && (
    (!ctrl_q[`SPF_C_MSTR] && !ssn_prev_q && slave_select_n && xfer_active) ||
    (ctrl_q[`SPF_C_MSTR] && ssn_prev_q && !slave_select_n));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_fault_flag_q <= 1'b0;
    end else if (mode_fault_flag_set) begin
      mode_fault_flag_q <= 1'b1;
    end else if (mode_fault_flag_clr) begin
      mode_fault_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side
  // [R22] Protected break blocks write
  // [R19] Transmit holding register
  always_ff @(posedge mclk) begin
    if (wr_data && !brk_block)
      tx_hold_q <= pwdata[7:0];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_empty_q <= 1'b1;
    // [R11] Set on hand-over
    end else if (tx_load) begin
      tx_empty_q <= 1'b1;
    // [R12] Cleared by data write
    end else if (wr_data && !brk_block) begin
      tx_empty_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, pin ownership and baud
  // [R2] Receive term
  // [R4] Error terms gated
  // [R11] Transmit term
  // [R23] Single OR output
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      irq_q <= 1'b0;
    else
      irq_q <= (rx_full_q && ctrl_q[`SPF_C_RXIE]) ||
               (error_irq_enable_q && (ovr_q || mode_fault_flag_q)) ||
               (tx_empty_q && ctrl_q[`SPF_C_TXIE]);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ss_owned_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      // [R15] Select pin ownership
      ss_owned_q <= ctrl_q[`SPF_C_SPE] &&
                    (!ctrl_q[`SPF_C_MSTR] || fault_detect_enable_q);
      // [R21] Slave output enable
      miso_oe_q <= ctrl_q[`SPF_C_SPE] && !ctrl_q[`SPF_C_MSTR] &&
                   !slave_select_n;
    end
  end

  // [R18] Rate used only as master
  assign bif.run = ctrl_q[`SPF_C_SPE] && ctrl_q[`SPF_C_MSTR];
  assign bif.rate_sel = rate_q;

  spf_baud u_baud (
    .mclk(mclk),
    .nrst(nrst),
    .bif(bif)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      baud_tick_q <= 1'b0;
    else
      baud_tick_q <= bif.tick;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_data = tx_hold_q;
  assign tx_pending = ~tx_empty_q;
  assign irq = irq_q;
  assign ss_owned = ss_owned_q;
  assign miso_oe = miso_oe_q;
  assign baud_tick = baud_tick_q;
  assign spi_enable = ctrl_q[`SPF_C_SPE];
  assign master_mode = ctrl_q[`SPF_C_MSTR];
  assign clk_polarity = ctrl_q[`SPF_C_CPOL];
  assign clk_phase = ctrl_q[`SPF_C_CPHA];
  assign wired_or = ctrl_q[`SPF_C_WOM];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_rx_armed;
    rd_stat && rx_full_q && !brk_block ##[1:20] rd_data && !brk_block;
  endsequence

  a_rx_full_set: assert property ( // [R1]
    rx_done |=> rx_full_q)
    else $error("receive full not set");

  a_rx_two_step: assert property ( // [R3]
    s_rx_armed ##0 (!rx_done && !rd_stat) |=> !rx_full_q)
    else $error("receive full not cleared");

  a_irq_or_form: assert property ( // [R23]
    ##1 irq_q == $past((rx_full_q && ctrl_q[`SPF_C_RXIE]) ||
      (error_irq_enable_q && (ovr_q || mode_fault_flag_q)) || (tx_empty_q && ctrl_q[`SPF_C_TXIE])))
    else $error("interrupt not the OR of enabled flags");

  a_err_masked: assert property ( // [R4]
    (!error_irq_enable_q && !ctrl_q[`SPF_C_RXIE] && !ctrl_q[`SPF_C_TXIE]) |=> !irq_q)
    else $error("masked error raised interrupt");

  a_ovr_on_full: assert property ( // [R5]
    rx_done && rx_full_q && !rx_clr |=> ovr_q)
    else $error("overrun not flagged");

  a_ovr_keeps_old: assert property ( // [R6]
    rx_done && rx_full_q && !rx_clr |=> $stable(rx_hold_q))
    else $error("old byte overwritten on overrun");

  a_mode_fault_flag_master: assert property ( // [R9]
    ctrl_q[`SPF_C_SPE] && ctrl_q[`SPF_C_MSTR] && fault_detect_enable_q &&
      ssn_prev_q && !slave_select_n |=> mode_fault_flag_q)
    else $error("master mode fault missed");

  a_mode_fault_flag_gated: assert property ( // [R14]
    !fault_detect_enable_q && !mode_fault_flag_q |=> !mode_fault_flag_q)
    else $error("mode fault set with detection off");

  a_mode_fault_flag_no_arm: assert property ( // [R24]
    wr_ctrl && !arm_mode_fault_flag_q && mode_fault_flag_q |=> mode_fault_flag_q)
    else $error("mode fault cleared without status read");

  a_tx_empty_clr: assert property ( // [R12]
    wr_data && !brk_block && !tx_load |=> !tx_empty_q ##1 tx_pending)
    else $error("transmit empty not cleared");

  a_break_write: assert property ( // [R22]
    wr_data && brk_block && !tx_load |=> $stable(tx_hold_q) &&
      $stable(tx_empty_q))
    else $error("write took effect in protected break");

  a_miso_drive: assert property ( // [R21]
    slave_select_n |=> !miso_oe_q)
    else $error("serial output driven while deselected");

endmodule

// File: testbench/spf_peer.sv
// Far-side shifter model: delivers received bytes, takes transmit bytes
// Assumes mclk of the flag block; all outputs change after rising edges
`timescale 1ns/1ps
module spf_peer (
  input wire logic mclk,
  output logic rx_done,
  output logic [7:0] rx_byte,
  output logic tx_load,
  output logic xfer_active
);
  initial begin
    rx_done = 1'b0;
    rx_byte = 8'h00;
    tx_load = 1'b0;
    xfer_active = 1'b0;
  end
  task automatic recv(input logic [7:0] b);
    @(posedge mclk);
    rx_done <= 1'b1;
    rx_byte <= b;
    @(posedge mclk);
    rx_done <= 1'b0;
    rx_byte <= ~b;
  endtask
  task automatic take();
    @(posedge mclk);
    tx_load <= 1'b1;
    @(posedge mclk);
    tx_load <= 1'b0;
  endtask
  task automatic busy(input logic v);
    @(posedge mclk);
    xfer_active <= v;
  endtask
endmodule

// File: testbench/spf_top_tb.sv
// Self-checking bench for the SPI flag block over APB
// Assumes the map header on the include path and the peer model
`timescale 1ns/1ps
`include "spf_map.svh"
module spf_top_tb;
  localparam logic [11:0] CTL = 12'h040;
  localparam logic [11:0] STA = 12'h044;
  localparam logic [11:0] DAT = 12'h048;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_done, tx_load, tx_pending, xfer_active;
  logic [7:0] rx_byte, tx_data;
  logic ss_n = 1'b1;
  logic brk = 1'b0;
  logic bce = 1'b0;
  logic irq, ss_owned, miso_oe, baud_tick;
  logic spi_enable, master_mode, clk_polarity, clk_phase, wired_or;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic err;
  always #2.5 mclk = ~mclk;
  spf_peer peer (.mclk(mclk), .rx_done(rx_done), .rx_byte(rx_byte),
    .tx_load(tx_load), .xfer_active(xfer_active));
  spf_top #(.ADDR_W(12)) dut (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_done(rx_done),
    .rx_byte(rx_byte), .tx_load(tx_load), .tx_data(tx_data),
    .tx_pending(tx_pending), .slave_select_n(ss_n),
    .xfer_active(xfer_active), .break_active(brk),
    .break_clear_enable(bce), .irq(irq), .ss_owned(ss_owned),
    .miso_oe(miso_oe), .baud_tick(baud_tick), .spi_enable(spi_enable),
    .master_mode(master_mode), .clk_polarity(clk_polarity),
    .clk_phase(clk_phase), .wired_or(wired_or));
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(CTL, `SPF_CTRL_RST);
    rchk(STA, 8'h08);
    chk(tx_pending, 1'b0);
    chk({spi_enable, master_mode, clk_polarity, clk_phase, wired_or},
        5'b01010);
    apb(1'b0, 12'h3F0, 8'h00);
    chk({rd[7:0], 7'h0, err}, 16'h0001);
  endtask
  task automatic t_rx();
    peer.recv(8'hA5);
    rchk(STA, 8'h88);
    wr(CTL, 8'hA8);
    cyc(2);
    chk(irq, 1'b1);
    rchk(DAT, 8'hA5);
    rchk(STA, 8'h08);
    cyc(2);
    chk(irq, 1'b0);
    wr(CTL, 8'h28);
  endtask
  task automatic t_ovr();
    wr(STA, 8'h40);
    peer.recv(8'h11);
    peer.recv(8'h22);
    cyc(2);
    chk(irq, 1'b1);
    rchk(DAT, 8'h11);
    rchk(STA, 8'hE8);
    rchk(DAT, 8'h11);
    rchk(STA, 8'h48);
    cyc(2);
    chk(irq, 1'b0);
    wr(STA, 8'h00);
  endtask
  task automatic t_tx();
    wr(CTL, 8'h29);
    cyc(2);
    chk(irq, 1'b1);
    wr(DAT, 8'h5A);
    chk({tx_pending, tx_data}, 9'h15A);
    rchk(DAT, 8'h11);
    rchk(STA, 8'h00);
    chk(irq, 1'b0);
    peer.take();
    rchk(STA, 8'h08);
    chk(irq, 1'b1);
    wr(CTL, 8'h28);
    brk <= 1'b1;
    wr(DAT, 8'h77);
    chk({tx_pending, tx_data}, 9'h05A);
    bce <= 1'b1;
    wr(DAT, 8'h77);
    chk({tx_pending, tx_data}, 9'h177);
    peer.take();
    brk <= 1'b0;
    bce <= 1'b0;
  endtask
  task automatic t_mode_fault_flag_m();
    wr(STA, 8'h04);
    wr(CTL, 8'h22);
    cyc(2);
    chk(ss_owned, 1'b1);
    chk({spi_enable, master_mode, clk_polarity, clk_phase, wired_or},
        5'b11000);
    ss_n <= 1'b0;
    cyc(3);
    rchk(STA, 8'h1C);
    wr(STA, 8'h00);
    rchk(STA, 8'h18);
    wr(CTL, 8'h22);
    rchk(STA, 8'h08);
    cyc(2);
    chk(ss_owned, 1'b0);
    ss_n <= 1'b1;
  endtask
  task automatic t_mode_fault_flag_s();
    wr(STA, 8'h04);
    wr(CTL, 8'h02);
    ss_n <= 1'b0;
    cyc(3);
    chk({miso_oe, ss_owned}, 2'b11);
    peer.busy(1'b1);
    ss_n <= 1'b1;
    cyc(3);
    chk(miso_oe, 1'b0);
    rchk(STA, 8'h1C);
    peer.busy(1'b0);
    wr(CTL, 8'h28);
    wr(STA, 8'h00);
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (baud_tick !== 1'b1 && n < 300);
  endtask
  task automatic t_baud();
    logic [7:0] bd [4];
    int n;
    bd = '{`SPF_BD_00, `SPF_BD_01, `SPF_BD_10, `SPF_BD_11};
    wr(CTL, 8'h22);
    for (int c = 0; c < 4; c++) begin
      wr(STA, 8'(c));
      gap(n);
      gap(n);
      gap(n);
      chk(32'(n), 32'(bd[c] / 2));
    end
    wr(CTL, 8'h02);
    cyc(2);
    gap(n);
    chk(32'(n), 32'd300);
    wr(CTL, 8'h28);
    wr(STA, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  initial begin
    cyc(20);
    nrst <= 1'b1;
    t_reset();
    t_rx();
    t_ovr();
    t_tx();
    t_mode_fault_flag_m();
    t_mode_fault_flag_s();
    t_baud();
    conclude();
  end
endmodule
